// file: core/tmr2_defs.svh
// offsets, field positions, reset values and tick counts of the capture/reload timer
// assumes byte-wide special function register access from the cpu core
// Functional notes
// - overflow_flag is set when the count rolls over from FFFF, only while both baud selects are 0, and hardware never clears it.
// - software writing one to overflow_flag raises the timer interrupt request when the timer interrupt is enabled.
// - with external_enable set, a falling edge on external_trigger_pin sets external_flag, which only software clears.
// - software setting external_flag raises the timer interrupt request when the timer interrupt is enabled.
// - the receive baud select picks the serial port 0 receive timebase: 0 timer 1 overflow, 1 this timer's overflow.
// - the transmit baud select picks the serial port 0 transmit timebase: 0 timer 1 overflow, 1 this timer's overflow.
// - either baud select forces baud generator mode, where the count advances once every two clocks regardless of counter_timer_select.
// - trigger pin edges cause capture or reload only with external_enable at 1 and no baud generation; with it at 0 the pin is ignored.
// - run_control at 1 counts and at 0 halts, keeping the count bytes unchanged except when a trigger pin reload occurs.
// - counter_timer_select 0 counts internal ticks at a rate set by tick_speed_select, 1 counts falling edges on count_input_pin.
// - with either baud select set, capture_reload_select is ignored and the count reloads after every overflow.
// - capture_reload_select 0 reloads on every overflow, and also on a trigger pin falling edge when external_enable is 1.
// - capture_reload_select 1 with external_enable 1 captures the running count on a trigger pin falling edge.
// - a capture copies count_low_byte into capture_reload_low and count_high_byte into capture_reload_high.
// - a reload takes capture_reload_low as the low byte and capture_reload_high as the high byte of the count.
// - the count is held in two readable and writable bytes, low and high, both reset to zero.
`ifndef TMR2_DEFS_SVH
`define TMR2_DEFS_SVH

// register offsets on the special function register bus
`define TMR2_OFS_CTRL    8'hC8
`define TMR2_OFS_CAP_LO  8'hCA
`define TMR2_OFS_CAP_HI  8'hCB
`define TMR2_OFS_CNT_LO  8'hCC
`define TMR2_OFS_CNT_HI  8'hCD

// timer_two_control field positions
`define TMR2_BIT_OVF     7
`define TMR2_BIT_EXF     6
`define TMR2_BIT_RXSEL   5
`define TMR2_BIT_TXSEL   4
`define TMR2_BIT_EXEN    3
`define TMR2_BIT_RUN     2
`define TMR2_BIT_CT      1
`define TMR2_BIT_CPRL    0

// reset values
`define TMR2_RST_BYTE    8'h00
`define TMR2_RST_CNT     16'h0000
`define TMR2_RST_PRE     4'h0

// roll-over point and prescaler terminal counts (divide minus one)
`define TMR2_CNT_MAX     16'hFFFF
`define TMR2_PRE_BAUD    4'h1
`define TMR2_PRE_SLOW    4'hB
`define TMR2_PRE_FAST    4'h3

`endif

// file: core/tmr2_edge.sv
// two-flop synchroniser and falling edge finder for the two timer pins
// assumes the pins are asynchronous to clk and held at least two clocks per level
`timescale 1ns/1ps
`include "tmr2_defs.svh"

module tmr2_edge
  import tmr2_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] fall_pulse
);

  tmr2_edge_s st_reg;
  tmr2_edge_s st_next;

  // next state: meta feeds only sync, edges are found after the second flop
  always_comb begin
    st_next      = st_reg;
    st_next.meta = pin_in;
    st_next.sync = st_reg.meta;
    st_next.last = st_reg.sync;
    for (int i = 0; i < 2; i++) begin
      st_next.fall[i] = st_reg.last[i] & ~st_reg.sync[i];
    end
  end

  // pins idle high, so reset to ones to avoid a false edge after release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{meta: 2'h3, sync: 2'h3, last: 2'h3, fall: 2'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign fall_pulse = st_reg.fall;

endmodule

// file: core/tmr2_pkg.sv
// types shared by the capture/reload timer modules
// assumes tmr2_defs.svh is included by each module that needs numbers
package tmr2_pkg;

  // what advances the count in a given cycle
  typedef enum logic [1:0] {
    TMR2_SRC_HALT,
    TMR2_SRC_BAUD,
    TMR2_SRC_COUNTER,
    TMR2_SRC_TIMER
  } tmr2_src_e;

  // state of the pin synchroniser and edge finder
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] last;
    logic [1:0] fall;
  } tmr2_edge_s;

  // whole state of the timer
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  cap_lo;
    logic [7:0]  cap_hi;
    logic [15:0] cnt;
    logic [3:0]  pre;
    logic [7:0]  rdata;
    logic        irq;
    logic        rx_tick;
    logic        tx_tick;
  } tmr2_state_s;

endpackage

// file: core/tmr2_top.sv
// 16-bit capture/reload timer with baud generator, on the cpu special function register bus
// assumes one-cycle rd/wr strobes from the core, timer1_ovf and int_enable on clk
`timescale 1ns/1ps
`include "tmr2_defs.svh"

module tmr2_top
  import tmr2_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       tick_speed_select,
  input  wire logic       int_enable,
  input  wire logic       timer1_ovf,
  input  wire logic       count_input_pin,
  input  wire logic       external_trigger_pin,
  output logic            irq_req,
  output logic            rx_baud_tick,
  output logic            tx_baud_tick
);

  tmr2_state_s st_reg;
  tmr2_state_s st_next;

  logic [1:0]  pin_fall;
  logic        cnt_fall;
  logic        trig_fall;

  // one-hot register select, shared by the read and write paths
  function automatic logic [4:0] sfr_decode(input logic [7:0] addr);
    logic [4:0] sel;
    sel    = 5'h00;
    sel[0] = (addr == `TMR2_OFS_CTRL);
    sel[1] = (addr == `TMR2_OFS_CAP_LO);
    sel[2] = (addr == `TMR2_OFS_CAP_HI);
    sel[3] = (addr == `TMR2_OFS_CNT_LO);
    sel[4] = (addr == `TMR2_OFS_CNT_HI);
    return sel;
  endfunction

  // both pins pass two flops before any edge logic sees them
  tmr2_edge tmr2_edge_i (
    .clk        (clk),
    .rst        (rst),
    .pin_in     ({external_trigger_pin, count_input_pin}),
    .fall_pulse (pin_fall)
  );

  assign cnt_fall  = pin_fall[0];
  assign trig_fall = pin_fall[1];

  // decoded control fields
  logic        ovf_flag;
  logic        ext_flag;
  logic        rx_sel;
  logic        tx_sel;
  logic        ext_en;
  logic        run;
  logic        ct_sel;
  logic        cprl_sel;
  logic        baud_mode;
  logic [4:0]  wr_sel;
  logic [4:0]  rd_sel;
  tmr2_src_e   src;
  logic [3:0]  pre_top;
  logic        tick;
  logic        ovf_evt;
  logic        ext_act;
  logic        do_reload;
  logic        do_capture;
  logic [15:0] reload_val;

  assign ovf_flag   = st_reg.ctrl[`TMR2_BIT_OVF];
  assign ext_flag   = st_reg.ctrl[`TMR2_BIT_EXF];
  assign rx_sel     = st_reg.ctrl[`TMR2_BIT_RXSEL];
  assign tx_sel     = st_reg.ctrl[`TMR2_BIT_TXSEL];
  assign ext_en     = st_reg.ctrl[`TMR2_BIT_EXEN];
  assign run        = st_reg.ctrl[`TMR2_BIT_RUN];
  assign ct_sel     = st_reg.ctrl[`TMR2_BIT_CT];
  assign cprl_sel   = st_reg.ctrl[`TMR2_BIT_CPRL];
  assign baud_mode  = rx_sel | tx_sel;
  assign wr_sel     = sfr_wr ? sfr_decode(sfr_addr) : 5'h00;
  assign rd_sel     = sfr_rd ? sfr_decode(sfr_addr) : 5'h00;
  assign reload_val = {st_reg.cap_hi, st_reg.cap_lo};

  // count source: baud mode overrides the counter/timer choice
  always_comb begin
    if (!run) begin
      src = TMR2_SRC_HALT;
    end else if (baud_mode) begin
      src = TMR2_SRC_BAUD;
    end else if (ct_sel) begin
      src = TMR2_SRC_COUNTER;
    end else begin
      src = TMR2_SRC_TIMER;
    end
  end

  // prescaler terminal count and the advance strobe for this cycle
  always_comb begin
    pre_top = `TMR2_RST_PRE;
    tick    = 1'b0;
    unique case (src)
      TMR2_SRC_HALT: begin
        tick = 1'b0;
      end
      TMR2_SRC_BAUD: begin
        pre_top = `TMR2_PRE_BAUD;
        tick    = (st_reg.pre == `TMR2_PRE_BAUD);
      end
      TMR2_SRC_COUNTER: begin
        tick = cnt_fall;
      end
      TMR2_SRC_TIMER: begin
        pre_top = tick_speed_select ? `TMR2_PRE_FAST : `TMR2_PRE_SLOW;
        tick    = (st_reg.pre >= pre_top);
      end
    endcase
  end

  // roll-over and trigger events
  assign ovf_evt    = tick & (st_reg.cnt == `TMR2_CNT_MAX);
  assign ext_act    = trig_fall & ext_en & ~baud_mode;
  assign do_reload  = (ovf_evt & (baud_mode | ~cprl_sel))
                    | (ext_act & ~cprl_sel);
  assign do_capture = ext_act & cprl_sel;

  // next state of the whole block
  always_comb begin
    st_next = st_reg;

    // prescaler only runs in the internally timed sources
    if (src == TMR2_SRC_TIMER || src == TMR2_SRC_BAUD) begin
      st_next.pre = tick ? `TMR2_RST_PRE : st_reg.pre + 4'h1;
    end else begin
      st_next.pre = `TMR2_RST_PRE;
    end

    // software writes land first so hardware events below win the cycle
    if (wr_sel[0]) begin
      st_next.ctrl = sfr_wdata;
    end
    if (wr_sel[1]) begin
      st_next.cap_lo = sfr_wdata;
    end
    if (wr_sel[2]) begin
      st_next.cap_hi = sfr_wdata;
    end

    // counting; a halted timer keeps its count unless a trigger reload lands
    if (tick) begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
    if (do_reload) begin
      st_next.cnt = reload_val;
    end
    if (do_capture) begin
      st_next.cap_lo = st_reg.cnt[7:0];
      st_next.cap_hi = st_reg.cnt[15:8];
    end

    // a byte write beats counting in that byte only
    if (wr_sel[3]) begin
      st_next.cnt[7:0] = sfr_wdata;
    end
    if (wr_sel[4]) begin
      st_next.cnt[15:8] = sfr_wdata;
    end

    // flags: a hardware set wins over a software clear in the same cycle
    if (ovf_evt && !baud_mode) begin
      st_next.ctrl[`TMR2_BIT_OVF] = 1'b1;
    end
    if (trig_fall && ext_en) begin
      st_next.ctrl[`TMR2_BIT_EXF] = 1'b1;
    end

    // request follows the registered flags, one cycle behind
    st_next.irq = int_enable & (ovf_flag | ext_flag);

    // serial port 0 timebases
    st_next.rx_tick = rx_sel ? (ovf_evt & baud_mode) : timer1_ovf;
    st_next.tx_tick = tx_sel ? (ovf_evt & baud_mode) : timer1_ovf;

    // read data returns the state before this cycle's update, zero if unmapped
    if (sfr_rd) begin
      st_next.rdata = ({8{rd_sel[0]}} & st_reg.ctrl)
                    | ({8{rd_sel[1]}} & st_reg.cap_lo)
                    | ({8{rd_sel[2]}} & st_reg.cap_hi)
                    | ({8{rd_sel[3]}} & st_reg.cnt[7:0])
                    | ({8{rd_sel[4]}} & st_reg.cnt[15:8]);
    end
  end

  // all registers clear at reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{ctrl: `TMR2_RST_BYTE, cap_lo: `TMR2_RST_BYTE, cap_hi: `TMR2_RST_BYTE,
                  cnt: `TMR2_RST_CNT, pre: `TMR2_RST_PRE, rdata: `TMR2_RST_BYTE,
                  irq: 1'b0, rx_tick: 1'b0, tx_tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign sfr_rdata    = st_reg.rdata;
  assign irq_req      = st_reg.irq;
  assign rx_baud_tick = st_reg.rx_tick;
  assign tx_baud_tick = st_reg.tx_tick;

  // checks on the timer's own behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // a software write of one into a flag bit of the control register
  sequence s_flag_write;
    wr_sel[0] && (sfr_wdata[`TMR2_BIT_OVF] || sfr_wdata[`TMR2_BIT_EXF]);
  endsequence

  sequence s_enabled_after;
    int_enable;
  endsequence

  // roll-over outside baud mode leaves the overflow flag set
  property p_ovf_set;
    (ovf_evt && !baud_mode) |=> ovf_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  // in baud mode the overflow flag never rises by itself
  property p_ovf_quiet_baud;
    (baud_mode && !ovf_flag && !wr_sel[0]) |=> !ovf_flag;
  endproperty
  a_ovf_quiet_baud: assert property (p_ovf_quiet_baud) else $error("flag set in baud mode");

  // a flag written by software reaches the request two cycles later
  property p_soft_irq;
    (s_flag_write ##1 s_enabled_after) |=> irq_req;
  endproperty
  a_soft_irq: assert property (p_soft_irq) else $error("soft flag gave no request");

  // a qualified trigger edge sets the external flag
  property p_ext_set;
    (trig_fall && ext_en) |=> ext_flag;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("external flag not set");

  // baud mode advances at most every second clock
  property p_baud_half;
    (tick && src == TMR2_SRC_BAUD) |=> !tick;
  endproperty
  a_baud_half: assert property (p_baud_half) else $error("baud tick too fast");

  // a halted timer with no writes or trigger action keeps its count
  property p_halt_hold;
    (!run && !wr_sel[3] && !wr_sel[4] && !ext_act) |=> $stable(st_reg.cnt);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("count moved while halted");

  // capture copies both count bytes
  property p_capture;
    (do_capture) |=> ({st_reg.cap_hi, st_reg.cap_lo} == $past(st_reg.cnt));
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  // reload without a count write loads the capture pair
  property p_reload;
    (do_reload && !wr_sel[3] && !wr_sel[4] && !wr_sel[1] && !wr_sel[2])
      |=> (st_reg.cnt == $past(reload_val));
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong");

  // the request stands while a flag and the enable stay
  property p_irq_hold;
    (int_enable && (ovf_flag || ext_flag)) |=> irq_req;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped early");

  // the request drops once no enabled flag is left
  property p_irq_idle;
    !(int_enable && (ovf_flag || ext_flag)) |=> !irq_req;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("request without a flag");

  // hardware never clears the overflow flag; only a control write may
  property p_ovf_keep;
    (ovf_flag && !wr_sel[0]) |=> ovf_flag;
  endproperty
  a_ovf_keep: assert property (p_ovf_keep) else $error("overflow flag lost");

  // the external flag also stays until software writes the control register
  property p_ext_keep;
    (ext_flag && !wr_sel[0]) |=> ext_flag;
  endproperty
  a_ext_keep: assert property (p_ext_keep) else $error("external flag lost");

  // receive select low: the timebase is timer 1 overflow, one cycle late
  property p_rx_t1;
    !rx_sel |=> (rx_baud_tick == $past(timer1_ovf));
  endproperty
  a_rx_t1: assert property (p_rx_t1) else $error("receive timebase wrong");

  // transmit select low: the timebase is timer 1 overflow, one cycle late
  property p_tx_t1;
    !tx_sel |=> (tx_baud_tick == $past(timer1_ovf));
  endproperty
  a_tx_t1: assert property (p_tx_t1) else $error("transmit timebase wrong");

endmodule

// file: tb/tmr2_cpu.sv
// cpu core model driving the special function register bus of the timer
// assumes the timer samples strobes on rising clk and answers reads one cycle later
`timescale 1ns/1ps

module tmr2_cpu (
  input  wire logic       clk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata,
  output logic            int_enable,
  output logic            timer1_ovf
);
  // bus idle at time zero
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    int_enable = 1'b0;
    timer1_ovf = 1'b0;
  end

  // one-cycle write strobe; data inverted after release so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_wdata <= ~d;
  endtask

  // one-cycle read strobe; data taken at the edge after the sampling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    d = sfr_rdata;
  endtask

  // interrupt enable level from the core
  task automatic ien(input logic v);
    @(posedge clk);
    int_enable <= v;
  endtask

  // one timer 1 overflow pulse, then a quiet gap
  task automatic t1();
    @(posedge clk);
    timer1_ovf <= 1'b1;
    @(posedge clk);
    timer1_ovf <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: tb/tmr2_top_bench.sv
// self-checking bench for the capture/reload timer
// assumes the cpu model tmr2_cpu and the design sources under core/
`timescale 1ns/1ps
`include "tmr2_defs.svh"

module tmr2_top_bench;
  logic       clk;
  logic       rst;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic [7:0] rv;
  logic       sfr_wr;
  logic       sfr_rd;
  logic       tick_speed_select;
  logic       int_enable;
  logic       timer1_ovf;
  logic [1:0] pins;
  logic       irq_req;
  logic       rx_baud_tick;
  logic       tx_baud_tick;
  logic [7:0] ofs [5] = '{`TMR2_OFS_CTRL, `TMR2_OFS_CAP_LO, `TMR2_OFS_CAP_HI,
                          `TMR2_OFS_CNT_LO, `TMR2_OFS_CNT_HI};
  int         error_cnt = 0;
  int         num_checks = 0;
  int         rx_n = 0;
  int         tx_n = 0;

  tmr2_top tmr2_top_i (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tick_speed_select(tick_speed_select),
    .int_enable(int_enable), .timer1_ovf(timer1_ovf), .count_input_pin(pins[0]),
    .external_trigger_pin(pins[1]), .irq_req(irq_req), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick)
  );

  tmr2_cpu tmr2_cpu_i (
    .clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .int_enable(int_enable),
    .timer1_ovf(timer1_ovf)
  );

  // 250 MHz
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // baud ticks counted on the falling edge, away from their launch
  always @(negedge clk) begin
    rx_n = rx_n + (rx_baud_tick === 1'b1);
    tx_n = tx_n + (tx_baud_tick === 1'b1);
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // range compare; an unknown never lands inside the range
  task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic rdr(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    tmr2_cpu_i.rd(a, rv);
    chk(rv, lo, hi);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdr(a, e, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tmr2_cpu_i.wr(a, d);
  endtask

  // control writes replace every bit, flags included
  task automatic wc(input logic [7:0] d);
    wr(`TMR2_OFS_CTRL, d);
  endtask

  // low byte at a, high byte at the next place
  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  task automatic irq_is(input logic e);
    chk({7'h00, irq_req}, {7'h00, e}, {7'h00, e});
  endtask

  // pin low for four clocks, then high long enough for the edge to act
  task automatic fall(input int w);
    pins[w] <= 1'b0;
    repeat (4) @(posedge clk);
    pins[w] <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  initial begin
    rst = 1'b1;
    tick_speed_select = 1'b0;
    pins = 2'b11;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reset values, then an unmapped place that keeps nothing
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    wr(8'hC9, 8'hA5);
    rd(8'hC9, 8'h00);
    // all bytes keep their values while halted
    foreach (ofs[i]) wr(ofs[i], 8'h30 + 8'(i));
    repeat (50) @(posedge clk);
    foreach (ofs[i]) rd(ofs[i], 8'h30 + 8'(i));
    // internal rate: divide by 12 slow, by 4 fast
    for (int s = 0; s < 2; s++) begin
      tick_speed_select <= s[0];
      w16(`TMR2_OFS_CNT_LO, 16'h0000);
      wc(8'h04);
      repeat (120) @(posedge clk);
      wc(8'h00);
      rdr(`TMR2_OFS_CNT_LO, s ? 8'h1D : 8'h09, s ? 8'h20 : 8'h0C);
    end
    // roll-over: reload from capture bytes, wrap to zero in capture mode
    tmr2_cpu_i.ien(1'b1);
    w16(`TMR2_OFS_CAP_LO, 16'hFFF0);
    for (int c = 0; c < 2; c++) begin
      w16(`TMR2_OFS_CNT_LO, 16'hFFFE);
      wc(8'h04 | 8'(c));
      repeat (40) @(posedge clk);
      rd(`TMR2_OFS_CTRL, 8'h84 | 8'(c));
      irq_is(1'b1);
      wc(8'h80 | 8'(c));
      rd(`TMR2_OFS_CNT_HI, c ? 8'h00 : 8'hFF);
      wc(8'h00);
      repeat (3) @(posedge clk);
      irq_is(1'b0);
    end
    // baud mode ignores counter and capture selects; other side follows timer 1
    w16(`TMR2_OFS_CAP_LO, 16'hFFFC);
    for (int k = 0; k < 2; k++) begin
      w16(`TMR2_OFS_CNT_LO, 16'hFFFC);
      wc(k ? 8'h17 : 8'h27);
      rx_n = 0;
      tx_n = 0;
      repeat (10) tmr2_cpu_i.t1();
      rd(`TMR2_OFS_CTRL, k ? 8'h17 : 8'h27);
      wc(8'h00);
      chk(8'(k ? tx_n : rx_n), 8'h0B, 8'h0E);
      chk(8'(k ? rx_n : tx_n), 8'h0A, 8'h0A);
    end
    // trigger pin: ignored, capture, reload, flag only in baud mode
    fall(1);
    rd(`TMR2_OFS_CTRL, 8'h00);
    w16(`TMR2_OFS_CNT_LO, 16'h1234);
    wc(8'h09);
    fall(1);
    rd(`TMR2_OFS_CAP_LO, 8'h34);
    rd(`TMR2_OFS_CAP_HI, 8'h12);
    rd(`TMR2_OFS_CTRL, 8'h49);
    irq_is(1'b1);
    w16(`TMR2_OFS_CNT_LO, 16'h0000);
    wc(8'h08);
    fall(1);
    rd(`TMR2_OFS_CNT_LO, 8'h34);
    rd(`TMR2_OFS_CNT_HI, 8'h12);
    w16(`TMR2_OFS_CNT_LO, 16'h0001);
    wc(8'h38);
    fall(1);
    rd(`TMR2_OFS_CNT_LO, 8'h01);
    rd(`TMR2_OFS_CTRL, 8'h78);
    // software-set flags request the interrupt only while enabled
    for (int k = 0; k < 2; k++) begin
      tmr2_cpu_i.ien(1'b0);
      wc(k ? 8'h40 : 8'h80);
      repeat (3) @(posedge clk);
      irq_is(1'b0);
      tmr2_cpu_i.ien(1'b1);
      repeat (3) @(posedge clk);
      irq_is(1'b1);
      wc(8'h00);
      repeat (3) @(posedge clk);
      irq_is(1'b0);
    end
    // counter mode counts count pin falls
    w16(`TMR2_OFS_CNT_LO, 16'h0000);
    wc(8'h06);
    repeat (5) fall(0);
    wc(8'h00);
    rd(`TMR2_OFS_CNT_LO, 8'h05);
    end_sim();
  end

  // watchdog: the run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
